// ==== hw/atc_sequencer.sv ====
// Arm and trigger sequencer shared by both sampling channels.
// Assumes an AXI4-Lite master on CLOCK_I and asynchronous trigger pins.
`timescale 1ns/1ps
module atc_sequencer (
   input  wire logic        CLOCK_I,
   input  wire logic        RST_N_I,
   input  wire logic        CE_I,
   // AXI4-Lite slave
   input  wire logic [7:0]  S_AXI_AWADDR_I,
   input  wire logic        S_AXI_AWVALID_I,
   output logic             S_AXI_AWREADY_O,
   input  wire logic [31:0] S_AXI_WDATA_I,
   input  wire logic [3:0]  S_AXI_WSTRB_I,
   input  wire logic        S_AXI_WVALID_I,
   output logic             S_AXI_WREADY_O,
   output logic [1:0]       S_AXI_BRESP_O,
   output logic             S_AXI_BVALID_O,
   input  wire logic        S_AXI_BREADY_I,
   input  wire logic [7:0]  S_AXI_ARADDR_I,
   input  wire logic        S_AXI_ARVALID_I,
   output logic             S_AXI_ARREADY_O,
   output logic [31:0]      S_AXI_RDATA_O,
   output logic [1:0]       S_AXI_RRESP_O,
   output logic             S_AXI_RVALID_O,
   input  wire logic        S_AXI_RREADY_I,
   // Arm and trigger pins
   input  wire logic [1:0]  ECL_TRIG_I,
   input  wire logic [7:0]  TTL_TRIG_I,
   input  wire logic        FRONT_EXTERNAL_ARM_INPUT_I,
   input  wire logic        CHANNEL1_LEVEL_ARM_I,
   input  wire logic        CHANNEL2_LEVEL_ARM_I,
   input  wire logic        SAMPLE_TRIG_I,
   input  wire logic        REF_OSC_RUNNING_I,
   // Sequencer outputs
   output logic             SAMPLE_O,
   output logic             ARMED_O,
   output logic [1:0]       STATE_O
);
   localparam int NP = 15;

   // Pin synchronisation
   logic [NP-1:0] pin_lvl;
   logic [NP-1:0] pin_rise;
   logic [NP-1:0] pin_fall;

   atc_sync #(.W(NP)) u_sync (
      .clk_i   (CLOCK_I),
      .rst_n_i (RST_N_I),
      .ce_i    (CE_I),
      .pin_i   ({REF_OSC_RUNNING_I, SAMPLE_TRIG_I, CHANNEL2_LEVEL_ARM_I,
                 CHANNEL1_LEVEL_ARM_I, FRONT_EXTERNAL_ARM_INPUT_I,
                 TTL_TRIG_I, ECL_TRIG_I}),
      .level_o (pin_lvl),
      .rise_o  (pin_rise),
      .fall_o  (pin_fall)
   );

   // Event of the source selected by one selector
   function automatic logic src_hit(input logic [3:0] sel,
                                    input logic [15:0] ev,
                                    input logic allow_imm);
      logic hit;
      hit = ev[sel];
      if (sel == atc_pkg::SRC_HOLD) begin
         hit = 1'b0;
      end else if (sel == atc_pkg::SRC_IMM && !allow_imm) begin
         hit = 1'b0;
      end
      return hit;
   endfunction

   // Register file and bus state
   logic                        aw_v_q, aw_v_d;
   logic [7:0]                  aw_a_q, aw_a_d;
   logic                        w_v_q, w_v_d;
   logic [31:0]                 w_d_q, w_d_d;
   logic [3:0]                  w_s_q, w_s_d;
   logic                        b_v_q, b_v_d;
   logic [1:0]                  b_r_q, b_r_d;
   logic                        r_v_q, r_v_d;
   logic [31:0]                 r_d_q, r_d_d;
   logic [1:0]                  r_r_q, r_r_d;
   logic [3:0]                  src1_q, src1_d;
   logic [3:0]                  src2_q, src2_d;
   logic [atc_pkg::CW-1:0]      pre_q, pre_d;
   logic                        chan_q, chan_d;
   logic [atc_pkg::CW-1:0]      spa_q, spa_d;
   logic [atc_pkg::AW_CNT-1:0]  armcnt_q, armcnt_d;
   logic [atc_pkg::AW_CNT-1:0]  armdly_q, armdly_d;
   logic                        cmd_init, cmd_abort, cmd_imm, cmd_bus;
   logic                        wr_go;
   logic [31:0]                 wmask;

   // Sequencer state
   atc_pkg::atc_state_e         st_q, st_d;
   logic                        post_q, post_d;
   logic                        dly_q, dly_d;
   logic [atc_pkg::AW_CNT-1:0]  dcnt_q, dcnt_d;
   logic [atc_pkg::CW-1:0]      precnt_q, precnt_d;
   logic [atc_pkg::CW-1:0]      postcnt_q, postcnt_d;
   logic [atc_pkg::AW_CNT-1:0]  rem_q, rem_d;
   logic                        samp_q, samp_d;
   logic [15:0]                 ev;
   logic                        osc_ok, trig_ev, arm_src, arm_ok;
   logic [atc_pkg::CW-1:0]      post_need;
   logic                        burst_end;

   always_comb begin
      wmask = {{8{w_s_q[3]}}, {8{w_s_q[2]}}, {8{w_s_q[1]}}, {8{w_s_q[0]}}};
   end

   // Bus slave and configuration registers
   always_comb begin
      aw_v_d   = aw_v_q;
      aw_a_d   = aw_a_q;
      w_v_d    = w_v_q;
      w_d_d    = w_d_q;
      w_s_d    = w_s_q;
      b_v_d    = b_v_q;
      b_r_d    = b_r_q;
      r_v_d    = r_v_q;
      r_d_d    = r_d_q;
      r_r_d    = r_r_q;
      src1_d   = src1_q;
      src2_d   = src2_q;
      pre_d    = pre_q;
      chan_d   = chan_q;
      spa_d    = spa_q;
      armcnt_d = armcnt_q;
      armdly_d = armdly_q;
      cmd_init  = 1'b0;
      cmd_abort = 1'b0;
      cmd_imm   = 1'b0;
      cmd_bus   = 1'b0;
      if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
         aw_v_d = 1'b1;
         aw_a_d = S_AXI_AWADDR_I;
      end
      if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
         w_v_d = 1'b1;
         w_d_d = S_AXI_WDATA_I;
         w_s_d = S_AXI_WSTRB_I;
      end
      if (b_v_q && S_AXI_BREADY_I) begin
         b_v_d = 1'b0;
      end
      wr_go = aw_v_q && w_v_q && !b_v_q;
      if (wr_go) begin
         aw_v_d = 1'b0;
         w_v_d  = 1'b0;
         b_v_d  = 1'b1;
         b_r_d  = atc_pkg::RESP_OKAY;
         case (aw_a_q)
            atc_pkg::ADDR_CTRL: begin
               if (w_s_q[0]) begin
                  cmd_init  = w_d_q[atc_pkg::CTRL_INIT];
                  cmd_abort = w_d_q[atc_pkg::CTRL_ABORT];
                  cmd_imm   = w_d_q[atc_pkg::CTRL_IMM];
                  cmd_bus   = w_d_q[atc_pkg::CTRL_BUS];
               end
            end
            atc_pkg::ADDR_SOURCE: begin
               if (w_s_q[0]) begin
                  src1_d = w_d_q[atc_pkg::SRC1_LSB +: 4];
                  // Immediate refused on selector 2
                  if (w_d_q[atc_pkg::SRC2_LSB +: 4] != atc_pkg::SRC_IMM) begin
                     src2_d = w_d_q[atc_pkg::SRC2_LSB +: 4];
                  end
               end
            end
            atc_pkg::ADDR_PRE_CH1, atc_pkg::ADDR_PRE_CH2: begin
               // Either channel overwrites the one shared count
               pre_d  = (pre_q & ~wmask[atc_pkg::CW-1:0])
                        | (w_d_q[atc_pkg::CW-1:0] & wmask[atc_pkg::CW-1:0]);
               chan_d = (aw_a_q == atc_pkg::ADDR_PRE_CH2);
            end
            atc_pkg::ADDR_SAMPLES: begin
               spa_d = (spa_q & ~wmask[atc_pkg::CW-1:0])
                       | (w_d_q[atc_pkg::CW-1:0] & wmask[atc_pkg::CW-1:0]);
            end
            atc_pkg::ADDR_ARMCNT: begin
               armcnt_d = (armcnt_q & ~wmask[atc_pkg::AW_CNT-1:0])
                          | (w_d_q[atc_pkg::AW_CNT-1:0]
                             & wmask[atc_pkg::AW_CNT-1:0]);
            end
            atc_pkg::ADDR_ARMDLY: begin
               armdly_d = (armdly_q & ~wmask[atc_pkg::AW_CNT-1:0])
                          | (w_d_q[atc_pkg::AW_CNT-1:0]
                             & wmask[atc_pkg::AW_CNT-1:0]);
            end
            atc_pkg::ADDR_STATUS, atc_pkg::ADDR_SAMPCNT: begin
               b_r_d = atc_pkg::RESP_OKAY;
            end
            default: begin
               b_r_d = atc_pkg::RESP_SLVERR;
            end
         endcase
      end
      if (r_v_q && S_AXI_RREADY_I) begin
         r_v_d = 1'b0;
      end
      if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
         r_v_d = 1'b1;
         r_r_d = atc_pkg::RESP_OKAY;
         r_d_d = 32'h00000000;
         case (S_AXI_ARADDR_I)
            atc_pkg::ADDR_CTRL: r_d_d = 32'h00000000;
            atc_pkg::ADDR_SOURCE: begin
               r_d_d[atc_pkg::SRC1_LSB +: 4] = src1_q;
               r_d_d[atc_pkg::SRC2_LSB +: 4] = src2_q;
            end
            atc_pkg::ADDR_PRE_CH1,
            atc_pkg::ADDR_PRE_CH2: r_d_d[atc_pkg::CW-1:0] = pre_q;
            atc_pkg::ADDR_SAMPLES: r_d_d[atc_pkg::CW-1:0] = spa_q;
            atc_pkg::ADDR_ARMCNT: r_d_d[atc_pkg::AW_CNT-1:0] = armcnt_q;
            atc_pkg::ADDR_ARMDLY: r_d_d[atc_pkg::AW_CNT-1:0] = armdly_q;
            atc_pkg::ADDR_STATUS: begin
               r_d_d[1:0]                    = st_q;
               r_d_d[atc_pkg::ST_CH_BIT]     = chan_q;
               r_d_d[atc_pkg::ST_OSC_BIT]    = osc_ok;
               r_d_d[atc_pkg::ST_ARM_BIT]    = post_q;
               r_d_d[atc_pkg::ST_REM_LSB +: atc_pkg::AW_CNT] = rem_q;
            end
            atc_pkg::ADDR_SAMPCNT:
               r_d_d[atc_pkg::CW-1:0] = precnt_q + postcnt_q;
            default: r_r_d = atc_pkg::RESP_SLVERR;
         endcase
      end
   end

   assign S_AXI_AWREADY_O = !aw_v_q;
   assign S_AXI_WREADY_O  = !w_v_q;
   assign S_AXI_BVALID_O  = b_v_q;
   assign S_AXI_BRESP_O   = b_r_q;
   assign S_AXI_ARREADY_O = !r_v_q;
   assign S_AXI_RVALID_O  = r_v_q;
   assign S_AXI_RDATA_O   = r_d_q;
   assign S_AXI_RRESP_O   = r_r_q;

   always_ff @(posedge CLOCK_I) begin
      if (!RST_N_I) begin
         aw_v_q   <= 1'b0;
         aw_a_q   <= 8'h00;
         w_v_q    <= 1'b0;
         w_d_q    <= 32'h00000000;
         w_s_q    <= 4'h0;
         b_v_q    <= 1'b0;
         b_r_q    <= atc_pkg::RESP_OKAY;
         r_v_q    <= 1'b0;
         r_d_q    <= 32'h00000000;
         r_r_q    <= atc_pkg::RESP_OKAY;
         src1_q   <= atc_pkg::RST_SRC1;
         src2_q   <= atc_pkg::RST_SRC2;
         pre_q    <= atc_pkg::RST_PRE;
         chan_q   <= 1'b0;
         spa_q    <= atc_pkg::RST_SAMPLES;
         armcnt_q <= atc_pkg::RST_ARMCNT;
         armdly_q <= atc_pkg::RST_ARMDLY;
      end else if (CE_I) begin
         aw_v_q   <= aw_v_d;
         aw_a_q   <= aw_a_d;
         w_v_q    <= w_v_d;
         w_d_q    <= w_d_d;
         w_s_q    <= w_s_d;
         b_v_q    <= b_v_d;
         b_r_q    <= b_r_d;
         r_v_q    <= r_v_d;
         r_d_q    <= r_d_d;
         r_r_q    <= r_r_d;
         src1_q   <= src1_d;
         src2_q   <= src2_d;
         pre_q    <= pre_d;
         chan_q   <= chan_d;
         spa_q    <= spa_d;
         armcnt_q <= armcnt_d;
         armdly_q <= armdly_d;
      end
   end

   // Arm events indexed by selector code
   always_comb begin
      osc_ok   = pin_lvl[14];
      trig_ev  = pin_rise[13];
      ev       = 16'h0000;
      // Immediate also arms the pre-arm path once its count is full
      ev[atc_pkg::SRC_IMM]  = (st_q == atc_pkg::ST_WAIT_ARM)
                              || (st_q == atc_pkg::ST_WAIT_TRIG);
      ev[atc_pkg::SRC_BUS]  = cmd_bus;
      ev[atc_pkg::SRC_ECL0] = pin_rise[0];
      ev[atc_pkg::SRC_ECL1] = pin_rise[1];
      ev[atc_pkg::SRC_TTL7:atc_pkg::SRC_TTL0] = pin_fall[9:2];
      ev[atc_pkg::SRC_EXT]  = pin_rise[10];
      ev[atc_pkg::SRC_LVL1] = pin_rise[11];
      ev[atc_pkg::SRC_LVL2] = pin_rise[12];
      arm_src = osc_ok && (src_hit(src1_q, ev, 1'b1)
                           || src_hit(src2_q, ev, 1'b0));
      arm_ok  = arm_src || cmd_imm;
      post_need = (spa_q > pre_q) ? spa_q - pre_q : atc_pkg::RST_SAMPLES;
      burst_end = post_q && trig_ev && (postcnt_q + 20'h00001 == post_need);
   end

   // Sequencer: one state drives both channels
   always_comb begin
      st_d      = st_q;
      post_d    = post_q;
      dly_d     = dly_q;
      dcnt_d    = dcnt_q;
      precnt_d  = precnt_q;
      postcnt_d = postcnt_q;
      rem_d     = rem_q;
      samp_d    = 1'b0;
      case (st_q)
         atc_pkg::ST_IDLE: begin
            if (cmd_init) begin
               st_d  = atc_pkg::ST_INITIATED;
               rem_d = armcnt_q;
            end
         end
         atc_pkg::ST_INITIATED: begin
            precnt_d  = '0;
            postcnt_d = '0;
            dly_d     = 1'b0;
            if (pre_q != '0) begin
               st_d   = atc_pkg::ST_WAIT_TRIG;
               post_d = 1'b0;
            end else begin
               st_d   = atc_pkg::ST_WAIT_ARM;
               post_d = 1'b1;
            end
         end
         atc_pkg::ST_WAIT_ARM: begin
            if (cmd_imm) begin
               st_d  = atc_pkg::ST_WAIT_TRIG;
               rem_d = (rem_q != '0) ? rem_q - 16'h0001 : rem_q;
            end else if (dly_q) begin
               if (dcnt_q == '0) begin
                  st_d  = atc_pkg::ST_WAIT_TRIG;
                  dly_d = 1'b0;
               end else begin
                  dcnt_d = dcnt_q - 16'h0001;
               end
            end else if (arm_src) begin
               rem_d = (rem_q != '0) ? rem_q - 16'h0001 : rem_q;
               if (armdly_q == '0) begin
                  st_d = atc_pkg::ST_WAIT_TRIG;
               end else begin
                  dly_d  = 1'b1;
                  dcnt_d = armdly_q - 16'h0001;
               end
            end
         end
         atc_pkg::ST_WAIT_TRIG: begin
            if (trig_ev) begin
               samp_d = 1'b1;
               if (!post_q && precnt_q != pre_q) begin
                  precnt_d = precnt_q + 20'h00001;
               end else if (post_q) begin
                  postcnt_d = postcnt_q + 20'h00001;
               end
            end
            // Arm counts only after pre-arm count is full
            if (!post_q && precnt_q == pre_q && arm_ok) begin
               post_d = 1'b1;
               rem_d  = (rem_q != '0) ? rem_q - 16'h0001 : rem_q;
            end
            if (burst_end) begin
               // Arm count zero runs until abort
               if (armcnt_q != '0 && rem_q == '0) begin
                  st_d = atc_pkg::ST_IDLE;
               end else begin
                  st_d = atc_pkg::ST_INITIATED;
               end
            end
         end
         default: begin
            st_d = atc_pkg::ST_IDLE;
         end
      endcase
      if (cmd_abort) begin
         st_d  = atc_pkg::ST_IDLE;
         dly_d = 1'b0;
      end
   end

   always_ff @(posedge CLOCK_I) begin
      if (!RST_N_I) begin
         st_q      <= atc_pkg::ST_IDLE;
         post_q    <= 1'b0;
         dly_q     <= 1'b0;
         dcnt_q    <= '0;
         precnt_q  <= '0;
         postcnt_q <= '0;
         rem_q     <= '0;
         samp_q    <= 1'b0;
      end else if (CE_I) begin
         st_q      <= st_d;
         post_q    <= post_d;
         dly_q     <= dly_d;
         dcnt_q    <= dcnt_d;
         precnt_q  <= precnt_d;
         postcnt_q <= postcnt_d;
         rem_q     <= rem_d;
         samp_q    <= samp_d;
      end
   end

   assign SAMPLE_O = samp_q;
   assign ARMED_O  = (st_q == atc_pkg::ST_WAIT_TRIG);
   assign STATE_O  = st_q;
endmodule

// ==== hw/atc_pkg.sv ====
// Constants, register map and types of the arm and trigger sequencer.
// Assumes a 32-bit AXI4-Lite register bus and one 25 MHz clock.
package atc_pkg;

   // Register byte addresses
   localparam logic [7:0] ADDR_CTRL     = 8'h00;
   localparam logic [7:0] ADDR_SOURCE   = 8'h04;
   localparam logic [7:0] ADDR_PRE_CH1  = 8'h08;
   localparam logic [7:0] ADDR_PRE_CH2  = 8'h0c;
   localparam logic [7:0] ADDR_SAMPLES  = 8'h10;
   localparam logic [7:0] ADDR_ARMCNT   = 8'h14;
   localparam logic [7:0] ADDR_ARMDLY   = 8'h18;
   localparam logic [7:0] ADDR_STATUS   = 8'h1c;
   localparam logic [7:0] ADDR_SAMPCNT  = 8'h20;

   // Control register bits (write-one pulses)
   localparam int CTRL_INIT  = 0;
   localparam int CTRL_ABORT = 1;
   localparam int CTRL_IMM   = 2;
   localparam int CTRL_BUS   = 3;

   // Field layouts
   localparam int CW         = 20;
   localparam int AW_CNT     = 16;
   localparam int SRC1_LSB   = 0;
   localparam int SRC2_LSB   = 4;
   localparam int ST_CH_BIT  = 2;
   localparam int ST_OSC_BIT = 3;
   localparam int ST_ARM_BIT = 4;
   localparam int ST_REM_LSB = 16;

   // Arm source selector codes
   typedef enum logic [3:0] {
      SRC_HOLD  = 4'h0,
      SRC_IMM   = 4'h1,
      SRC_BUS   = 4'h2,
      SRC_ECL0  = 4'h3,
      SRC_ECL1  = 4'h4,
      SRC_TTL0  = 4'h5,
      SRC_TTL7  = 4'hc,
      SRC_EXT   = 4'hd,
      SRC_LVL1  = 4'he,
      SRC_LVL2  = 4'hf
   } atc_src_e;

   // Reset values
   localparam logic [3:0]        RST_SRC1    = 4'h1;
   localparam logic [3:0]        RST_SRC2    = 4'h0;
   localparam logic [CW-1:0]     RST_PRE     = 20'h00000;
   localparam logic [CW-1:0]     RST_SAMPLES = 20'h00001;
   localparam logic [AW_CNT-1:0] RST_ARMCNT  = 16'h0001;
   localparam logic [AW_CNT-1:0] RST_ARMDLY  = 16'h0000;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      ST_IDLE      = 2'b00,
      ST_INITIATED = 2'b01,
      ST_WAIT_ARM  = 2'b10,
      ST_WAIT_TRIG = 2'b11
   } atc_state_e;

endpackage

// ==== hw/atc_sync.sv ====
// Two-stage synchroniser with edge detection for asynchronous pins.
// Assumes pins are asynchronous to CLOCK_I; frozen while ce_i is low.
`timescale 1ns/1ps
module atc_sync #(
   parameter int W = 1
) (
   input  wire logic         clk_i,
   input  wire logic         rst_n_i,
   input  wire logic         ce_i,
   input  wire logic [W-1:0] pin_i,
   output logic      [W-1:0] level_o,
   output logic      [W-1:0] rise_o,
   output logic      [W-1:0] fall_o
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;
   logic [W-1:0] prev_q;

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         meta_q <= '0;
         sync_q <= '0;
         prev_q <= '0;
      end else if (ce_i) begin
         meta_q <= pin_i;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   assign level_o = sync_q;
   assign rise_o  = sync_q & ~prev_q;
   assign fall_o  = ~sync_q & prev_q;
endmodule

// ==== dv/atc_sequencer_monitor.sv ====
// Checker of sequencer state and sample outputs.
// Assumes binding to atc_sequencer; sees only its ports.
`timescale 1ns/1ps
module atc_sequencer_monitor (
   input wire logic        CLOCK_I,
   input wire logic        RST_N_I,
   input wire logic        CE_I,
   input wire logic [7:0]  S_AXI_AWADDR_I,
   input wire logic        S_AXI_AWVALID_I,
   input wire logic        S_AXI_AWREADY_O,
   input wire logic [31:0] S_AXI_WDATA_I,
   input wire logic [3:0]  S_AXI_WSTRB_I,
   input wire logic        S_AXI_WVALID_I,
   input wire logic        S_AXI_WREADY_O,
   input wire logic        SAMPLE_O,
   input wire logic        ARMED_O,
   input wire logic [1:0]  STATE_O
);
   default clocking cb @(posedge CLOCK_I);
   endclocking
   default disable iff (!RST_N_I);

   sequence wr_abort_s;
      S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I &&
      S_AXI_WREADY_O && S_AXI_AWADDR_I == atc_pkg::ADDR_CTRL &&
      S_AXI_WSTRB_I[0] && S_AXI_WDATA_I[atc_pkg::CTRL_ABORT];
   endsequence
   sequence left_s(logic [1:0] s);
      $past(STATE_O) == s && STATE_O != s;
   endsequence

   reset_idle_a: assert property (disable iff (1'b0)
      !RST_N_I && CE_I |=> STATE_O == atc_pkg::ST_IDLE)
      else $error("state not idle after reset");
   abort_idle_a: assert property (
      wr_abort_s |-> ##[1:3] STATE_O == atc_pkg::ST_IDLE)
      else $error("abort did not reach idle");
   idle_exit_a: assert property (
      left_s(atc_pkg::ST_IDLE) |-> STATE_O == atc_pkg::ST_INITIATED)
      else $error("idle left to wrong state");
   init_once_a: assert property (
      STATE_O == atc_pkg::ST_INITIATED && CE_I
      |=> STATE_O != atc_pkg::ST_INITIATED)
      else $error("initiated held too long");
   arm_exit_a: assert property (
      left_s(atc_pkg::ST_WAIT_ARM) |->
      STATE_O inside {atc_pkg::ST_WAIT_TRIG, atc_pkg::ST_IDLE})
      else $error("wait-arm left to wrong state");
   trig_exit_a: assert property (
      left_s(atc_pkg::ST_WAIT_TRIG) |->
      STATE_O inside {atc_pkg::ST_INITIATED, atc_pkg::ST_IDLE})
      else $error("wait-trigger left to wrong state");
   armed_state_a: assert property (
      ARMED_O == (STATE_O == atc_pkg::ST_WAIT_TRIG))
      else $error("armed flag disagrees with state");
   sample_armed_a: assert property (
      SAMPLE_O |-> $past(ARMED_O))
      else $error("sample taken while not armed");
endmodule

bind atc_sequencer atc_sequencer_monitor u_mon (
   .CLOCK_I(CLOCK_I), .RST_N_I(RST_N_I), .CE_I(CE_I),
   .S_AXI_AWADDR_I(S_AXI_AWADDR_I), .S_AXI_AWVALID_I(S_AXI_AWVALID_I),
   .S_AXI_AWREADY_O(S_AXI_AWREADY_O), .S_AXI_WDATA_I(S_AXI_WDATA_I),
   .S_AXI_WSTRB_I(S_AXI_WSTRB_I), .S_AXI_WVALID_I(S_AXI_WVALID_I),
   .S_AXI_WREADY_O(S_AXI_WREADY_O), .SAMPLE_O(SAMPLE_O),
   .ARMED_O(ARMED_O), .STATE_O(STATE_O)
);

// ==== dv/atc_trig_model.sv ====
// Trigger-line model: pulses one selected arm or sample line.
// Assumes fire_i is a one-cycle request on the bench clock.
`timescale 1ns/1ps
module atc_trig_model (
   input  wire logic       clk_i,
   input  wire logic       fire_i,
   input  wire logic [3:0] sel_i,
   input  wire logic [2:0] len_i,
   output logic [1:0]      ecl_o,
   output logic [7:0]      ttl_o,
   output logic            ext_o,
   output logic            lvl1_o,
   output logic            lvl2_o,
   output logic            trig_o
);
   logic [2:0]  cnt_q = 3'h0;
   logic [3:0]  sel_q = 4'h0;
   logic [15:0] hot;
   always_ff @(posedge clk_i) begin
      if (fire_i) begin
         cnt_q <= len_i;
         sel_q <= sel_i;
      end else if (cnt_q != 3'h0) begin
         cnt_q <= cnt_q - 3'h1;
      end
   end
   // Code 0 drives the sample trigger
   assign hot    = (cnt_q != 3'h0) ? (16'h1 << sel_q) : 16'h0;
   assign trig_o = hot[0];
   assign ecl_o  = hot[4:3];
   assign ttl_o  = ~hot[12:5];
   assign ext_o  = hot[13];
   assign lvl1_o = hot[14];
   assign lvl2_o = hot[15];
endmodule

// ==== dv/tb_top.sv ====
// Self-checking bench of the arm and trigger sequencer.
// Assumes the trigger-line model and the bound checker.
`timescale 1ns/1ps
module tb_top;
   logic        clk = 1'b0, rst_n = 1'b0, ce = 1'b1, osc = 1'b1;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata;
   logic        awv = 1'b0, wv = 1'b0, bready = 1'b0;
   logic        arv = 1'b0, rready = 1'b0, fire = 1'b0;
   logic        awr, wrd, bv, arr, rv, ext, l1, l2, trig, smp;
   logic [1:0]  bresp, rresp, ecl;
   logic [7:0]  ttl;
   logic [3:0]  sel = 4'h0;
   logic [2:0]  len = 3'h4;
   logic [15:0] lf = 16'h8;
   logic [33:0] e_q[$], m_q[$];
   int          n_fail = 0, compares = 0, cyc = 0;

   atc_sequencer dut (
      .CLOCK_I(clk), .RST_N_I(rst_n), .CE_I(ce),
      .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awv),
      .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wdata),
      .S_AXI_WSTRB_I(4'hf), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wrd),
      .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(bready),
      .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arv),
      .S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp),
      .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rready),
      .ECL_TRIG_I(ecl), .TTL_TRIG_I(ttl),
      .FRONT_EXTERNAL_ARM_INPUT_I(ext),
      .CHANNEL1_LEVEL_ARM_I(l1), .CHANNEL2_LEVEL_ARM_I(l2),
      .SAMPLE_TRIG_I(trig), .REF_OSC_RUNNING_I(osc),
      .SAMPLE_O(smp), .ARMED_O(), .STATE_O()
   );
   atc_trig_model u_trg (
      .clk_i(clk), .fire_i(fire), .sel_i(sel), .len_i(len),
      .ecl_o(ecl), .ttl_o(ttl), .ext_o(ext), .lvl1_o(l1),
      .lvl2_o(l2), .trig_o(trig)
   );

   initial begin
      forever #20 clk = ~clk;
   end

   function automatic logic [15:0] nx(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction

   task automatic wrap_up;
      if (n_fail == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(input logic [33:0] g);
      logic [33:0] e, m;
      e = e_q.pop_front();
      m = m_q.pop_front();
      compares++;
      if ((g & m) !== (e & m)) begin
         n_fail++;
         $display("[FAIL] %0t got %h exp %h", $time, g & m, e & m);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] r);
      logic ap, dp;
      ap = 1'b1;
      dp = 1'b1;
      @(posedge clk);
      e_q.push_back({r, 32'h0});
      m_q.push_back({2'h3, 32'h0});
      awaddr <= a;
      wdata <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      bready <= 1'b1;
      while (ap || dp) begin
         @(posedge clk);
         if (ap && awr === 1'b1) begin
            ap = 1'b0;
            awv <= 1'b0;
         end
         if (dp && wrd === 1'b1) begin
            dp = 1'b0;
            wv <= 1'b0;
         end
      end
      do @(posedge clk); while (bv !== 1'b1);
      bready <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [33:0] e,
                     input logic [31:0] m);
      @(posedge clk);
      e_q.push_back(e);
      m_q.push_back({2'h3, m});
      araddr <= a;
      arv <= 1'b1;
      rready <= 1'b1;
      do @(posedge clk); while (arr !== 1'b1);
      arv <= 1'b0;
      do @(posedge clk); while (rv !== 1'b1);
      rready <= 1'b0;
   endtask

   task automatic st(input logic [1:0] s);
      rd(atc_pkg::ADDR_STATUS, {32'h0, s}, 32'h3);
   endtask

   // Pin pulse of random width, then the synchroniser latency
   task automatic pulse(input logic [3:0] s);
      @(posedge clk);
      if (s == 4'h0) begin
         e_q.push_back({2'h3, 32'h0});
         m_q.push_back({2'h3, 32'hffffffff});
      end
      sel <= s;
      len <= 3'h2 + {1'b0, lf[1:0]};
      fire <= 1'b1;
      lf = nx(lf);
      @(posedge clk);
      fire <= 1'b0;
      repeat (12) @(posedge clk);
   endtask

   task automatic init;
      wr(atc_pkg::ADDR_CTRL, 32'h1, 2'h0);
   endtask

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (rv === 1'b1 && rready)
         chk({rresp, rdata});
      if (bv === 1'b1 && bready)
         chk({bresp, 32'h0});
      if (smp === 1'b1)
         chk({2'h3, 32'h0});
      if (cyc == 20000) begin
         n_fail++;
         wrap_up();
      end
   end

   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      rd(atc_pkg::ADDR_SOURCE, 34'h1, 32'hff);
      st(2'h0);
      wr(8'h40, 32'h0, atc_pkg::RESP_SLVERR);
      rd(8'h40, {atc_pkg::RESP_SLVERR, 32'h0}, 32'hffffffff);
      wr(atc_pkg::ADDR_PRE_CH1, {12'h0, 4'h3, lf}, 2'h0);
      wr(atc_pkg::ADDR_PRE_CH2, 32'h2, 2'h0);
      rd(atc_pkg::ADDR_PRE_CH1, 34'h2, 32'hfffff);
      rd(atc_pkg::ADDR_STATUS, 34'h4, 32'h4);
      wr(atc_pkg::ADDR_SAMPLES, 32'h4, 2'h0);
      wr(atc_pkg::ADDR_SOURCE, 32'hd, 2'h0);
      init();
      st(2'h3);
      pulse(4'hd);
      repeat (4) pulse(4'h0);
      st(2'h3);
      pulse(4'hd);
      pulse(4'h0);
      st(2'h3);
      pulse(4'h0);
      st(2'h0);
      wr(atc_pkg::ADDR_PRE_CH1, 32'h0, 2'h0);
      wr(atc_pkg::ADDR_SAMPLES, 32'h3, 2'h0);
      wr(atc_pkg::ADDR_ARMCNT, 32'h2, 2'h0);
      wr(atc_pkg::ADDR_ARMDLY, 32'h8, 2'h0);
      init();
      st(2'h2);
      pulse(4'hd);
      st(2'h3);
      repeat (2) pulse(4'h0);
      st(2'h3);
      pulse(4'h0);
      st(2'h2);
      wr(atc_pkg::ADDR_CTRL, 32'h4, 2'h0);
      rd(atc_pkg::ADDR_STATUS, 34'h3, 32'hffff0003);
      repeat (3) pulse(4'h0);
      st(2'h0);
      osc <= 1'b0;
      wr(atc_pkg::ADDR_ARMCNT, 32'h1, 2'h0);
      wr(atc_pkg::ADDR_ARMDLY, 32'h0, 2'h0);
      wr(atc_pkg::ADDR_SAMPLES, 32'h1, 2'h0);
      init();
      pulse(4'hd);
      st(2'h2);
      osc <= 1'b1;
      pulse(4'hd);
      st(2'h3);
      pulse(4'h0);
      st(2'h0);
      ce <= 1'b0;
      repeat (3) @(posedge clk);
      ce <= 1'b1;
      for (int i = 2; i < 16; i++) begin
         wr(atc_pkg::ADDR_SOURCE, i[0] ? 32'(i) << 4 : 32'(i), 2'h0);
         init();
         pulse(i == 13 ? 4'he : 4'hd);
         st(2'h2);
         if (i == 2)
            wr(atc_pkg::ADDR_CTRL, 32'h8, 2'h0);
         else
            pulse(4'(i));
         st(2'h3);
         wr(atc_pkg::ADDR_CTRL, 32'h2, 2'h0);
         st(2'h0);
      end
      wr(atc_pkg::ADDR_SOURCE, 32'h1, 2'h0);
      init();
      st(2'h3);
      rst_n <= 1'b0;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      st(2'h0);
      @(posedge clk);
      wrap_up();
   end
endmodule
